// File: prast_rasterizer.sv
// primitive rasterizer: edge-walks trapezoids, steps lines, emits points.
// assumes the register master and fragment consumer share core_clk_i;
// frag_ready_i and flush_done_i are same-clock logic, not synchronised.
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module prast_rasterizer
  import prast_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  // fragment stream
  output logic             frag_valid_o,
  input  wire logic        frag_ready_i,
  output logic      [15:0] frag_x_o,
  output logic      [15:0] frag_y_o,
  output logic             frag_subpix_o,
  output logic             frag_block_fill_o,
  // framebuffer flush handshake
  output logic             flush_req_o,
  input  wire logic        flush_done_i
);

  // ----------------------------------------------------------------
  // host-visible shadow registers
  // ----------------------------------------------------------------
  logic [31:0]            dominant_edge_start_x;
  logic [31:0]            dominant_edge_slope;
  logic [31:0]            subordinate_edge_start_x;
  logic [31:0]            subordinate_edge_slope;
  logic [31:0]            first_scanline_y;
  logic [31:0]            y_step_delta;
  logic [CNT_W-1:0]       count;
  logic [31:0]            raster_config;
  logic [31:0]            draw_cmd;
  logic [CNT_W-1:0]       resume_count;
  prast_resume_type       resume_kind;
  logic                   draw_pend;
  logic                   cont_pend;
  logic                   flush_pend;

  // working edge state, loaded from the shadows only when a command is taken; px, span_end and span_l2r are set per scanline
  prast_state_type        state;
  prast_kind_type         wk_kind;
  logic [31:0]            dom_x;
  logic [31:0]            sub_x;
  logic [31:0]            cur_y;
  logic [31:0]            dom_dx;
  logic [31:0]            sub_dx;
  logic [31:0]            wk_dy;
  logic [CNT_W-1:0]       remaining;
  logic [15:0]            px;
  logic [15:0]            span_end;
  logic                   span_l2r;
  logic                   wk_subpix;
  logic                   wk_ffill;

  logic                   wr_draw;
  logic                   wr_cont;
  logic                   take_draw;
  logic                   take_cont;
  logic                   fire;
  logic                   in_span;
  logic [31:0]            next_dom_x;
  logic [31:0]            next_cur_y;
  prast_kind_type         cmd_kind;

  assign wr_draw  = reg_wr_i && (reg_addr_i == REG_DRAW);
  assign wr_cont  = reg_wr_i && (reg_addr_i == REG_RESUME || reg_addr_i == REG_RESUME_SUB
                                 || reg_addr_i == REG_RESUME_DOM || reg_addr_i == REG_RESUME_SEG);
  // a pending sync holds back any new primitive until the flush is done
  assign take_draw = (state == st_idle) && draw_pend && !flush_pend;
  assign take_cont = (state == st_idle) && !draw_pend && cont_pend && !flush_pend;
  assign fire      = frag_valid_o && frag_ready_i;
  assign cmd_kind  = prast_kind_type'(draw_cmd[CMD_KIND_LSB +: 2]);
  assign next_dom_x = dom_x + dom_dx;
  assign next_cur_y = cur_y + wk_dy;
  // right-hand edge pixel is excluded in both scan directions
  assign in_span = span_l2r ? ($signed(px) < $signed(span_end))
                            : ($signed(px) >= $signed(span_end));

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // shadows only; edge walking uses its own copies, so reloading
  // these while a primitive is in flight does not disturb it
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dominant_edge_start_x    <= RESET_WORD;
      dominant_edge_slope      <= RESET_WORD;
      subordinate_edge_start_x <= RESET_WORD;
      subordinate_edge_slope   <= RESET_WORD;
      first_scanline_y         <= RESET_WORD;
      y_step_delta             <= RESET_WORD;
      count                    <= CNT_ZERO;
      raster_config            <= RASTER_CFG_DEF;
      draw_cmd                 <= RESET_WORD;
      resume_count             <= CNT_ZERO;
      resume_kind              <= resume_plain;
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        REG_DOM_START_X: dominant_edge_start_x    <= reg_wdata_i;
        REG_DOM_SLOPE:   dominant_edge_slope      <= reg_wdata_i;
        REG_SUB_START_X: subordinate_edge_start_x <= reg_wdata_i;
        REG_SUB_SLOPE:   subordinate_edge_slope   <= reg_wdata_i;
        REG_FIRST_Y:     first_scanline_y         <= reg_wdata_i;
        REG_Y_STEP:      y_step_delta             <= reg_wdata_i;
        REG_COUNT:       count                    <= reg_wdata_i[CNT_W-1:0];
        REG_RASTER_CFG:  raster_config            <= reg_wdata_i;
        REG_DRAW:        draw_cmd                 <= reg_wdata_i;
        REG_RESUME:
        begin
          resume_kind  <= resume_plain;
          resume_count <= reg_wdata_i[CNT_W-1:0];
        end
        REG_RESUME_SUB:
        begin
          resume_kind  <= resume_with_new_subordinate;
          resume_count <= reg_wdata_i[CNT_W-1:0];
        end
        REG_RESUME_DOM:
        begin
          resume_kind  <= resume_with_new_dominant;
          resume_count <= reg_wdata_i[CNT_W-1:0];
        end
        REG_RESUME_SEG:
        begin
          resume_kind  <= resume_with_new_segment;
          resume_count <= reg_wdata_i[CNT_W-1:0];
        end
        default:
        begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pending command flags
  // ----------------------------------------------------------------
  // a new write in the take cycle wins, so a command written in that cycle is not lost
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      draw_pend  <= 1'b0;
      cont_pend  <= 1'b0;
      flush_pend <= 1'b0;
    end
    else
    begin
      draw_pend  <= wr_draw || (draw_pend && !take_draw);
      cont_pend  <= wr_cont || (cont_pend && !take_cont);
      flush_pend <= (reg_wr_i && reg_addr_i == REG_SYNC)
                    || (flush_pend && !flush_done_i);
    end
  end

  assign flush_req_o = flush_pend;

  // ----------------------------------------------------------------
  // edge walker and fragment generator
  // ----------------------------------------------------------------
  // one fragment per two cycles at best; the output register keeps
  // frag data glitch free at the cost of throughput
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state        <= st_idle;
      wk_kind      <= kind_trapezoid;
      dom_x        <= RESET_WORD;
      sub_x        <= RESET_WORD;
      cur_y        <= RESET_WORD;
      dom_dx       <= RESET_WORD;
      sub_dx       <= RESET_WORD;
      wk_dy        <= RESET_WORD;
      remaining    <= CNT_ZERO;
      px           <= RESET_WORD[15:0];
      span_end     <= RESET_WORD[15:0];
      span_l2r     <= 1'b0;
      wk_subpix    <= 1'b0;
      wk_ffill     <= 1'b0;
      frag_valid_o <= 1'b0;
      frag_x_o     <= RESET_WORD[15:0];
      frag_y_o     <= RESET_WORD[15:0];
    end
    else
    begin
      case (state)
        st_idle:
        begin
          if (take_draw)
          begin
            // full reload of all steppers from the shadows
            wk_kind   <= cmd_kind;
            dom_x     <= dominant_edge_start_x;
            sub_x     <= subordinate_edge_start_x;
            cur_y     <= first_scanline_y;
            dom_dx    <= dominant_edge_slope;
            sub_dx    <= subordinate_edge_slope;
            wk_dy     <= y_step_delta;
            remaining <= count;
            wk_subpix <= draw_cmd[CMD_SUBPIX_BIT];
            wk_ffill  <= draw_cmd[CMD_FFILL_BIT];
            case (cmd_kind)
              kind_trapezoid: state <= st_span_begin;
              kind_line:      state <= st_line_step;
              kind_point:     state <= st_point;
              default:        state <= st_idle;
            endcase
          end
          else if (take_cont)
          begin
            remaining <= resume_count;
            case (resume_kind)
              resume_with_new_subordinate:
              begin
                sub_x <= subordinate_edge_start_x;
                sub_dx <= subordinate_edge_slope;
              end
              resume_with_new_dominant:
              begin
                dom_x  <= dominant_edge_start_x;
                dom_dx <= dominant_edge_slope;
              end
              resume_with_new_segment:
              begin
                dom_dx <= dominant_edge_slope;
                wk_dy  <= y_step_delta;
                if (raster_config[CFG_SEG_CENTER])
                begin
                  dom_x <= {dom_x[31:16], PIX_CENTER};
                  cur_y <= {cur_y[31:16], PIX_CENTER};
                end
              end
              default:
              begin
              end
            endcase
            // plain resume keeps all accumulated edge values and reloads only the count
            case (wk_kind)
              kind_trapezoid: state <= st_span_begin;
              kind_line:      state <= st_line_step;
              default:        state <= st_idle;
            endcase
          end
        end
        st_span_begin:
        begin
          // edge crossings may cross over: bow ties just flip direction
          if (remaining == CNT_ZERO)
          begin
            state <= st_idle;
          end
          else
          begin
            span_l2r <= $signed(sub_x[31:16]) > $signed(dom_x[31:16]);
            px       <= ($signed(sub_x[31:16]) > $signed(dom_x[31:16]))
                        ? dom_x[31:16] : dom_x[31:16] - PIX_ONE;
            span_end <= sub_x[31:16];
            state    <= st_span_pix;
          end
        end
        st_span_pix:
        begin
          if (in_span)
          begin
            frag_x_o     <= px;
            frag_y_o     <= cur_y[31:16];
            frag_valid_o <= 1'b1;
            state        <= st_frag_out;
          end
          else
          begin
            state <= st_span_end;
          end
        end
        st_span_end:
        begin
          // step both edges to the next scanline
          dom_x     <= next_dom_x;
          sub_x     <= sub_x + sub_dx;
          cur_y     <= next_cur_y;
          remaining <= remaining - CNT_ONE;
          state     <= st_span_begin;
        end
        st_line_step:
        begin
          if (remaining == CNT_ZERO)
          begin
            state <= st_idle;
          end
          else
          begin
            // add first, then plot the integer parts
            dom_x        <= next_dom_x;
            cur_y        <= next_cur_y;
            frag_x_o     <= next_dom_x[31:16];
            frag_y_o     <= next_cur_y[31:16];
            frag_valid_o <= 1'b1;
            state        <= st_frag_out;
          end
        end
        st_point:
        begin
          frag_x_o     <= dom_x[31:16];
          frag_y_o     <= cur_y[31:16];
          frag_valid_o <= 1'b1;
          state        <= st_frag_out;
        end
        st_frag_out:
        begin
          if (frag_ready_i)
          begin
            frag_valid_o <= 1'b0;
            case (wk_kind)
              kind_trapezoid:
              begin
                px    <= span_l2r ? px + PIX_ONE : px - PIX_ONE;
                state <= st_span_pix;
              end
              kind_line:
              begin
                remaining <= remaining - CNT_ONE;
                state     <= st_line_step;
              end
              default: state <= st_idle;
            endcase
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  // fragment side flags follow the primitive that made the fragment
  assign frag_subpix_o     = wk_subpix;
  assign frag_block_fill_o = wk_ffill && (wk_kind == kind_trapezoid);

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      reg_rdata_o <= RESET_WORD;
    end
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        REG_DOM_START_X: reg_rdata_o <= dominant_edge_start_x;
        REG_DOM_SLOPE:   reg_rdata_o <= dominant_edge_slope;
        REG_SUB_START_X: reg_rdata_o <= subordinate_edge_start_x;
        REG_SUB_SLOPE:   reg_rdata_o <= subordinate_edge_slope;
        REG_FIRST_Y:     reg_rdata_o <= first_scanline_y;
        REG_Y_STEP:      reg_rdata_o <= y_step_delta;
        REG_COUNT:       reg_rdata_o <= {16'h0000, count};
        REG_RASTER_CFG:  reg_rdata_o <= raster_config;
        REG_DRAW:        reg_rdata_o <= draw_cmd;
        REG_STATUS:
        begin
          reg_rdata_o               <= RESET_WORD;
          reg_rdata_o[ST_BUSY_BIT]  <= (state != st_idle);
          reg_rdata_o[ST_DRAW_BIT]  <= draw_pend;
          reg_rdata_o[ST_CONT_BIT]  <= cont_pend;
          reg_rdata_o[ST_FLUSH_BIT] <= flush_pend;
          reg_rdata_o[ST_REM_LSB +: CNT_W] <= remaining;
        end
        default:         reg_rdata_o <= RESET_WORD;
      endcase
    end
    else
    begin
      reg_rdata_o <= RESET_WORD;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking chk_clk @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  chk_frag_hold: assert property (frag_valid_o && !frag_ready_i |=> frag_valid_o && $stable(frag_x_o))
    else $error("fragment changed while stalled");
  chk_right_edge: assert property (state == st_span_pix && in_span && span_l2r
                                   |-> $signed(px) < $signed(sub_x[31:16]))
    else $error("right edge pixel emitted");
  chk_point_once: assert property (fire && wk_kind == kind_point |=> state == st_idle)
    else $error("point emitted more than once");
  chk_draw_start: assert property (take_draw && cmd_kind inside {kind_trapezoid, kind_line, kind_point}
                                   |=> state != st_idle)
    else $error("draw command not started");
  chk_flush_block: assert property (state == st_idle && flush_pend |=> state == st_idle)
    else $error("primitive started before flush");
  chk_cont_wait: assert property (cont_pend && state != st_idle |=> cont_pend)
    else $error("continue lost while busy");
  chk_line_add: assert property (state == st_line_step && remaining != CNT_ZERO
                                 |=> dom_x == $past(dom_x) + $past(dom_dx) && frag_x_o == dom_x[31:16])
    else $error("line step did not add delta");
  chk_line_count: assert property (fire && wk_kind == kind_line |=> remaining == $past(remaining) - CNT_ONE)
    else $error("line count not decremented");
  chk_newsub_load: assert property (take_cont && resume_kind == resume_with_new_subordinate
                                    |=> sub_x == $past(subordinate_edge_start_x)
                                        && remaining == $past(resume_count))
    else $error("subordinate edge not reloaded");

  cov_trapezoid: cover property (take_draw && cmd_kind == kind_trapezoid ##[1:200] fire);
  cov_line_seg:  cover property (take_cont && resume_kind == resume_with_new_segment);
  cov_point:     cover property (fire && wk_kind == kind_point);
  cov_sync:      cover property (flush_pend ##1 !flush_pend);

endmodule
`default_nettype wire

// File: prast_pkg.sv
// primitive rasterizer shared constants: register map, command fields,
// primitive kinds, state encoding.
// assumes a single 25 MHz core clock and a plain strobe register port.
package prast_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_DOM_START_X  = 8'h00;
  localparam logic [7:0] REG_DOM_SLOPE    = 8'h04;
  localparam logic [7:0] REG_SUB_START_X  = 8'h08;
  localparam logic [7:0] REG_SUB_SLOPE    = 8'h0C;
  localparam logic [7:0] REG_FIRST_Y      = 8'h10;
  localparam logic [7:0] REG_Y_STEP       = 8'h14;
  localparam logic [7:0] REG_COUNT        = 8'h18;
  localparam logic [7:0] REG_RASTER_CFG   = 8'h1C;
  localparam logic [7:0] REG_DRAW         = 8'h20;
  localparam logic [7:0] REG_RESUME       = 8'h24;
  localparam logic [7:0] REG_RESUME_SUB   = 8'h28;
  localparam logic [7:0] REG_RESUME_DOM   = 8'h2C;
  localparam logic [7:0] REG_RESUME_SEG   = 8'h30;
  localparam logic [7:0] REG_SYNC         = 8'h34;
  localparam logic [7:0] REG_STATUS       = 8'h38;

  // ----------------------------------------------------------------
  // field positions and widths
  // ----------------------------------------------------------------
  localparam int          CNT_W          = 16;
  localparam int          CMD_KIND_LSB   = 0;
  localparam int          CMD_SUBPIX_BIT = 2;
  localparam int          CMD_FFILL_BIT  = 3;
  localparam int          CFG_SEG_CENTER = 0;
  localparam int          ST_BUSY_BIT    = 0;
  localparam int          ST_DRAW_BIT    = 1;
  localparam int          ST_CONT_BIT    = 2;
  localparam int          ST_FLUSH_BIT   = 3;
  localparam int          ST_REM_LSB     = 16;
  localparam logic [31:0] RESET_WORD     = 32'h0000_0000;
  localparam logic [31:0] RASTER_CFG_DEF = 32'h0000_0000;
  localparam logic [15:0] PIX_CENTER     = 16'h8000;
  localparam logic [15:0] PIX_ONE        = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_ONE   = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 16'h0000;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    kind_trapezoid = 2'h0,
    kind_line      = 2'h1,
    kind_point     = 2'h2
  } prast_kind_type;

  typedef enum logic [1:0] {
    resume_plain,
    resume_with_new_subordinate,
    resume_with_new_dominant,
    resume_with_new_segment
  } prast_resume_type;

  typedef enum {
    st_idle,
    st_span_begin,
    st_span_pix,
    st_span_end,
    st_line_step,
    st_point,
    st_frag_out
  } prast_state_type;

endpackage

// File: prast_frag_sink.sv
// downstream fragment consumer and framebuffer flush partner.
// assumes one clock shared with the rasterizer; slow_i makes it stall.
`timescale 1ns/1ps
`default_nettype none
module prast_frag_sink
(
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  // control from bench
  input  wire logic slow_i,
  // fragment and flush handshakes
  input  wire logic flush_req_i,
  output logic      frag_ready_o,
  output logic      flush_done_o
);
  logic [1:0] wait_cnt;
  // ready toggles when slow, so a fragment that arrives while it is low stalls one cycle
  always_ff @(posedge core_clk_i or negedge rst_n_i)
    if (!rst_n_i) frag_ready_o <= 1'b0;
    else          frag_ready_o <= slow_i ? ~frag_ready_o : 1'b1;
  // flush answered late, so a waiting primitive is visible
  always_ff @(posedge core_clk_i or negedge rst_n_i)
    if (!rst_n_i) {wait_cnt, flush_done_o} <= 3'h0;
    else
    begin
      flush_done_o <= flush_req_i && (wait_cnt == 2'h3) && !flush_done_o;
      wait_cnt     <= (flush_req_i && !flush_done_o) ? wait_cnt + 2'h1 : 2'h0;
    end
endmodule
`default_nettype wire

// File: primitive_rasterizer_tb_top.sv
// self-checking bench: register writes in, accepted fragments judged.
// assumes prast_pkg compiled first; sink model stands downstream.
`timescale 1ns/1ps
`default_nettype none
module primitive_rasterizer_tb_top;
  import prast_pkg::*;
  logic core_clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, slow = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, rd_val;
  logic frag_valid_o, frag_ready, frag_subpix_o, frag_block_fill_o, flush_req_o, flush_done;
  logic [15:0] frag_x_o, frag_y_o;
  logic [33:0] got[$], exp[$];
  int mismatches = 0, compares = 0, cycles = 0;
  always #20 core_clk_i = ~core_clk_i;
  prast_rasterizer prast_rasterizer_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .frag_valid_o(frag_valid_o), .frag_ready_i(frag_ready), .frag_x_o(frag_x_o), .frag_y_o(frag_y_o),
    .frag_subpix_o(frag_subpix_o), .frag_block_fill_o(frag_block_fill_o), .flush_req_o(flush_req_o),
    .flush_done_i(flush_done));
  prast_frag_sink prast_frag_sink_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .slow_i(slow),
    .flush_req_i(flush_req_o), .frag_ready_o(frag_ready), .flush_done_o(flush_done));
  // collect every accepted fragment with its flags
  always @(posedge core_clk_i)
  begin
    cycles++;
    if (rst_n_i && frag_valid_o === 1'b1 && frag_ready === 1'b1)
      got.push_back({frag_block_fill_o, frag_subpix_o, frag_x_o, frag_y_o});
    if (cycles == 20000)
    begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (mismatches == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp_word(input logic [33:0] g, input logic [33:0] e, input string what);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge core_clk_i);
    rd_val = reg_rdata_o;
  endtask
  // expected fragment: integer x,y plus subpixel and fill flags
  task automatic ex(input int x, input int y, input logic sp, input logic bf);
    exp.push_back({bf, sp, 16'(x), 16'(y)});
  endtask
  // wait bounded for the expected fragments, then compare in order
  task automatic frags_match();
    for (int i = 0; i < 600 && got.size() < exp.size(); i++) @(posedge core_clk_i);
    repeat (20) @(posedge core_clk_i);
    cmp_word(34'(got.size()), 34'(exp.size()), "fragment count");
    foreach (exp[i]) if (i < got.size()) cmp_word(got[i], exp[i], "fragment");
    got.delete();
    exp.delete();
  endtask
  task automatic edges(input int dx, input int ds, input int sx, input int ss, input int y, input int dy);
    wr(REG_DOM_START_X, 32'(dx));
    wr(REG_DOM_SLOPE, 32'(ds));
    wr(REG_SUB_START_X, 32'(sx));
    wr(REG_SUB_SLOPE, 32'(ss));
    wr(REG_FIRST_Y, 32'(y));
    wr(REG_Y_STEP, 32'(dy));
  endtask
  task automatic t_point();
    wr(REG_RASTER_CFG, RASTER_CFG_DEF);
    edges(5 << 16, 0, 0, 0, 7 << 16, 0);
    wr(REG_DRAW, 32'h4 | 32'(kind_point));
    ex(5, 7, 1'b1, 1'b0);
    frags_match();
  endtask
  task automatic t_trap_stall();
    slow <= 1'b1;
    edges(2 << 16, 0, 5 << 16, 0, 1 << 16, 1 << 16);
    wr(REG_COUNT, 32'h2);
    wr(REG_DRAW, 32'h8 | 32'(kind_trapezoid));
    for (int y = 1; y <= 2; y++) for (int x = 2; x <= 4; x++) ex(x, y, 1'b0, 1'b1);
    frags_match();
    slow <= 1'b0;
    edges(6 << 16, 0, 3 << 16, 0, 4 << 16, 1 << 16);
    wr(REG_COUNT, 32'h1);
    wr(REG_DRAW, 32'(kind_trapezoid));
    for (int x = 5; x >= 3; x--) ex(x, 4, 1'b0, 1'b0);
    frags_match();
  endtask
  task automatic t_knee();
    // pointed top: both edges start at the apex, empty first row
    edges(3 << 16, 0, 3 << 16, 1 << 16, 0, 1 << 16);
    wr(REG_COUNT, 32'h3);
    wr(REG_DRAW, 32'(kind_trapezoid));
    ex(3, 1, 1'b0, 1'b0);
    ex(3, 2, 1'b0, 1'b0);
    ex(4, 2, 1'b0, 1'b0);
    frags_match();
    edges(2 << 16, 0, 4 << 16, 0, 0, 1 << 16);
    wr(REG_COUNT, 32'h1);
    wr(REG_DRAW, 32'(kind_trapezoid));
    wr(REG_SUB_START_X, 32'(6 << 16));
    wr(REG_RESUME_SUB, 32'h1);
    for (int x = 2; x <= 3; x++) ex(x, 0, 1'b0, 1'b0);
    for (int x = 2; x <= 5; x++) ex(x, 1, 1'b0, 1'b0);
    frags_match();
    wr(REG_RESUME, 32'h1);
    for (int x = 2; x <= 5; x++) ex(x, 2, 1'b0, 1'b0);
    frags_match();
    wr(REG_DOM_START_X, 32'(4 << 16));
    wr(REG_RESUME_DOM, 32'h1);
    ex(4, 3, 1'b0, 1'b0);
    ex(5, 3, 1'b0, 1'b0);
    frags_match();
  endtask
  task automatic t_line();
    edges(0, 1 << 16, 0, 0, 0, 32'h8000);
    wr(REG_COUNT, 32'h3);
    wr(REG_DRAW, 32'(kind_line));
    ex(1, 0, 1'b0, 1'b0);
    ex(2, 1, 1'b0, 1'b0);
    ex(3, 1, 1'b0, 1'b0);
    frags_match();
    wr(REG_Y_STEP, 32'(1 << 16));
    wr(REG_RESUME_SEG, 32'h2);
    ex(4, 2, 1'b0, 1'b0);
    ex(5, 3, 1'b0, 1'b0);
    frags_match();
    // centring mode: half-pixel X step tells it apart from plain restart
    wr(REG_DOM_SLOPE, 32'h0000_8000);
    wr(REG_RASTER_CFG, 32'h0000_0001);
    wr(REG_RESUME_SEG, 32'h1);
    ex(6, 4, 1'b0, 1'b0);
    frags_match();
    wr(REG_RASTER_CFG, RASTER_CFG_DEF);
  endtask
  task automatic t_sync_regs();
    wr(REG_DOM_START_X, 32'(4 << 16));
    wr(REG_FIRST_Y, 32'(3 << 16));
    wr(REG_COUNT, 32'h5);
    wr(REG_SYNC, 32'h1);
    wr(REG_DRAW, 32'(kind_point));
    @(negedge core_clk_i);
    cmp_word(34'(flush_req_o), 34'h1, "flush request");
    cmp_word(34'(got.size()), 34'h0, "held by flush");
    ex(4, 3, 1'b0, 1'b0);
    frags_match();
    rd(REG_DOM_START_X);
    cmp_word(34'(rd_val), 34'(4 << 16), "start x readback");
    rd(REG_STATUS);
    cmp_word(34'(rd_val), 34'h0_0005_0000, "idle status");
    rd(8'h3C);
    cmp_word(34'(rd_val), 34'h0, "unmapped read");
  endtask
  initial
  begin
    repeat (5) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    t_point();
    t_trap_stall();
    t_knee();
    t_line();
    t_sync_regs();
    report_and_stop();
  end
endmodule
`default_nettype wire
